// file: core/wdt_pkg.sv
// constants shared by the watchdog device end and its controller end
// assumes a single 200 MHz clock for both ends
package wdt_pkg;

	// ==========================================================
	// device register map (12-bit core register space)
	localparam logic [11:0] UNLOCK_CTRL_ADDR = 12'hFF0;
	localparam logic [11:0] RELOAD_UPPER_ADDR = 12'hFF1;
	localparam logic [11:0] RELOAD_HIGH_ADDR = 12'hFF2;
	localparam logic [11:0] RELOAD_LOW_ADDR = 12'hFF3;
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
	localparam logic [23:0] RELOAD_RESET = 24'h000400;
	localparam logic [23:0] NO_REFRESH_COUNT = 24'h000002;
	localparam logic [23:0] MIN_RELOAD = 24'h000004;
	localparam logic [23:0] TIMEOUT_COUNT = 24'h000000;
	// reset cause status bit positions
	localparam int WDT_FLAG_BIT = 5;
	localparam int STOP_FLAG_BIT = 4;

	// ==========================================================
	// timing: oscillator tick derived from the system clock
	localparam int OSC_PERIOD_NS = 100000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;

	// ==========================================================
	// controller apb register map
	localparam logic [7:0] APB_ACCESS_ADDR = 8'h00;
	localparam logic [7:0] APB_MODE_ADDR = 8'h04;
	localparam logic [7:0] APB_REFRESH_ADDR = 8'h08;
	localparam logic [7:0] APB_EVENTS_ADDR = 8'h0C;
	localparam int ACCESS_READ_BIT = 24;
	localparam int ACCESS_VALID_BIT = 8;
	localparam int MODE_DEBUG_BIT = 0;
	localparam int MODE_STOP_BIT = 1;

endpackage

// file: core/wdt_if.sv
// link between the watchdog device and the core-side controller
// assumes both ends share CLK and RSTN
`timescale 1ns/1ps
`default_nettype none

interface wdt_if;
	logic [11:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic refresh;
	logic debug_mode;
	logic stop_mode;
	logic timeout_irq;
	logic sys_reset_req;
	logic stop_recover;

	modport dev (
		input reg_addr, reg_wr, reg_rd, reg_wdata, refresh, debug_mode,
		input stop_mode,
		output reg_rdata, timeout_irq, sys_reset_req, stop_recover
	);
	modport ctl (
		output reg_addr, reg_wr, reg_rd, reg_wdata, refresh, debug_mode,
		output stop_mode,
		input reg_rdata, timeout_irq, sys_reset_req, stop_recover
	);
endinterface

`default_nettype wire

// file: core/wdt_device.sv
// 24-bit watchdog device end: unlock logic, reload, counter, time-out
// assumes the controller drives the link from the same clock
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module wdt_device #(
	parameter int unsigned TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
	input wire logic CLK,
	input wire logic RSTN,
	wdt_if.dev BUS,
	input wire logic ALWAYS_ON,
	input wire logic RESPONSE_SELECT,
	output logic RUNNING,
	output logic [23:0] COUNT
);
	import wdt_pkg::*;

	// ==========================================================
	// types and state
	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	typedef enum logic [2:0] {
		LK_IDLE = 3'b000,
		LK_KEY1 = 3'b001,
		LK_OPEN = 3'b011,
		LK_UPPER = 3'b010,
		LK_HIGH = 3'b110
	} lock_e;

	typedef struct packed {
		lock_e lock;
		logic [23:0] reload;
		logic [23:0] count;
		logic enabled;
		logic [TW-1:0] tick;
		logic wdt_flag;
		logic stop_flag;
		logic irq;
		logic sys_rst;
		logic stop_rec;
		logic [7:0] rdata;
		logic [1:0] ao_sync;
		logic [1:0] res_sync;
	} state_s;

	state_s s;
	state_s next_s;
	logic tick_now;
	logic wr_ctl;
	logic [23:0] count_dec;

	// ==========================================================
	// elaboration check
	if (TICK_CYCLES < 2) begin : g_tick_check
		$error("TICK_CYCLES must be at least 2");
	end

	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		tick_now = (s.tick == TW'(TICK_CYCLES - 1));
		wr_ctl = (BUS.reg_addr == UNLOCK_CTRL_ADDR);
		count_dec = s.count - 24'h000001;
		next_s.ao_sync = {s.ao_sync[0], ALWAYS_ON};
		next_s.res_sync = {s.res_sync[0], RESPONSE_SELECT};
		next_s.irq = 1'b0;
		next_s.sys_rst = 1'b0;
		next_s.stop_rec = 1'b0;

		next_s.tick = tick_now ? '0 : s.tick + TW'(1);

		// ======================================================
		// unlock sequence
		if (BUS.reg_wr) begin
			next_s.lock = LK_IDLE;
			unique case (s.lock)
				LK_IDLE: begin
					if (wr_ctl && BUS.reg_wdata == UNLOCK_KEY_FIRST) begin
						next_s.lock = LK_KEY1;
					end
				end
				LK_KEY1: begin
					if (wr_ctl && BUS.reg_wdata == UNLOCK_KEY_SECOND) begin
						next_s.lock = LK_OPEN;
					end
				end
				LK_OPEN: begin
					if (BUS.reg_addr == RELOAD_UPPER_ADDR) begin
						next_s.reload[23:16] = BUS.reg_wdata;
						next_s.lock = LK_UPPER;
					end
				end
				LK_UPPER: begin
					if (BUS.reg_addr == RELOAD_HIGH_ADDR) begin
						next_s.reload[15:8] = BUS.reg_wdata;
						next_s.lock = LK_HIGH;
					end
				end
				LK_HIGH: begin
					if (BUS.reg_addr == RELOAD_LOW_ADDR) begin
						next_s.reload[7:0] = BUS.reg_wdata;
					end
				end
				default: begin
					next_s.lock = LK_IDLE;
				end
			endcase
		end

		// ======================================================
		// register reads
		if (BUS.reg_rd) begin
			next_s.rdata = 8'h00;
			if (wr_ctl) begin
				next_s.rdata[WDT_FLAG_BIT] = s.wdt_flag;
				next_s.rdata[STOP_FLAG_BIT] = s.stop_flag;
				next_s.wdt_flag = 1'b0;
				next_s.stop_flag = 1'b0;
			end else if (BUS.reg_addr == RELOAD_UPPER_ADDR) begin
				next_s.rdata = s.count[23:16];
			end else if (BUS.reg_addr == RELOAD_HIGH_ADDR) begin
				next_s.rdata = s.count[15:8];
			end else if (BUS.reg_addr == RELOAD_LOW_ADDR) begin
				next_s.rdata = s.count[7:0];
			end
		end

		// ======================================================
		// counter
		if (!s.enabled) begin
			if (BUS.refresh || s.ao_sync[1]) begin
				next_s.enabled = 1'b1;
				next_s.count = s.reload;
				next_s.tick = '0;
			end
		end else if (BUS.debug_mode) begin
			next_s.count = s.reload;
			next_s.tick = '0;
		// refresh refused at two or below
		end else if (BUS.refresh && s.count > NO_REFRESH_COUNT) begin
			next_s.count = s.reload;
			next_s.tick = '0;
		end else if (tick_now) begin
			// count down forever, zero wraps to all-ones
			next_s.count = count_dec;
			if (count_dec == TIMEOUT_COUNT) begin
				next_s.wdt_flag = 1'b1;
				if (BUS.stop_mode) begin
					next_s.stop_flag = 1'b1;
					next_s.stop_rec = 1'b1;
					next_s.irq = !s.res_sync[1];
				end else if (s.res_sync[1]) begin
					next_s.sys_rst = 1'b1;
				end else begin
					next_s.irq = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s <= '0;
			s.reload <= RELOAD_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign BUS.reg_rdata = s.rdata;
	assign BUS.timeout_irq = s.irq;
	assign BUS.sys_reset_req = s.sys_rst;
	assign BUS.stop_recover = s.stop_rec;
	assign RUNNING = s.enabled;
	assign COUNT = s.count;

endmodule

`default_nettype wire

// file: core/wdt_controller.sv
// core-side controller: apb slave that drives the watchdog link
// assumes a single-clock apb master on CLK
`timescale 1ns/1ps
`default_nettype none

module wdt_controller (
	input wire logic CLK,
	input wire logic RSTN,
	wdt_if.ctl BUS,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	import wdt_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic rd_pend;
		logic [7:0] rdata;
		logic rd_valid;
		logic debug;
		logic stop;
		logic refresh;
		logic [2:0] events;
		logic [31:0] prdata;
	} state_s;

	state_s s;
	state_s next_s;
	logic do_write;

	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.wr = 1'b0;
		next_s.rd = 1'b0;
		next_s.refresh = 1'b0;
		next_s.rd_pend = s.rd;
		do_write = PSEL && PENABLE && PWRITE;
		if (s.rd_pend) begin
			next_s.rdata = BUS.reg_rdata;
			next_s.rd_valid = 1'b1;
		end
		if (do_write) begin
			if (PADDR == APB_ACCESS_ADDR) begin
				// one link write or read per order
				next_s.addr = PWDATA[19:8];
				next_s.wdata = PWDATA[7:0];
				if (PWDATA[ACCESS_READ_BIT]) begin
					next_s.rd = 1'b1;
					next_s.rd_valid = 1'b0;
				end else begin
					next_s.wr = 1'b1;
				end
			end else if (PADDR == APB_MODE_ADDR) begin
				next_s.debug = PWDATA[MODE_DEBUG_BIT];
				next_s.stop = PWDATA[MODE_STOP_BIT];
			end else if (PADDR == APB_REFRESH_ADDR) begin
				next_s.refresh = 1'b1;
			end else if (PADDR == APB_EVENTS_ADDR) begin
				next_s.events = s.events & ~PWDATA[2:0];
			end
		end
		// event capture, set beats clear
		next_s.events = next_s.events |
			{BUS.stop_recover, BUS.sys_reset_req, BUS.timeout_irq};
		// read data prepared in the setup cycle
		next_s.prdata = 32'h00000000;
		if (PSEL && !PENABLE && !PWRITE) begin
			if (PADDR == APB_ACCESS_ADDR) begin
				next_s.prdata[7:0] = s.rdata;
				next_s.prdata[ACCESS_VALID_BIT] = s.rd_valid;
			end else if (PADDR == APB_MODE_ADDR) begin
				next_s.prdata[MODE_DEBUG_BIT] = s.debug;
				next_s.prdata[MODE_STOP_BIT] = s.stop;
			end else if (PADDR == APB_EVENTS_ADDR) begin
				next_s.prdata[2:0] = s.events;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign BUS.reg_addr = s.addr;
	assign BUS.reg_wdata = s.wdata;
	assign BUS.reg_wr = s.wr;
	assign BUS.reg_rd = s.rd;
	assign BUS.refresh = s.refresh;
	assign BUS.debug_mode = s.debug;
	assign BUS.stop_mode = s.stop;
	assign PRDATA = s.prdata;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;

endmodule

`default_nettype wire

// file: sim/wdt_asserts.sv
// checker on the watchdog link signals
// assumes one clock, placed beside the link in the bench
`timescale 1ns/1ps
`default_nettype none
module wdt_asserts (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [11:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic debug_mode,
	input wire logic stop_mode,
	input wire logic timeout_irq,
	input wire logic sys_reset_req,
	input wire logic stop_recover
);
	import wdt_pkg::*;
	// ==========================================================
	// flag shadow
	logic st_rd, pulse, wf, sf, wnow, snow;
	assign st_rd = reg_rd && reg_addr == UNLOCK_CTRL_ADDR;
	assign pulse = timeout_irq || sys_reset_req || stop_recover;
	assign wnow = wf || pulse;
	assign snow = sf || stop_recover;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wf <= 1'b0;
			sf <= 1'b0;
		end else begin
			wf <= wnow && !st_rd;
			sf <= snow && !st_rd;
		end
	end
	// ==========================================================
	// properties
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence status_read;
		st_rd;
	endsequence
	chk_irq_pulse: assert property (timeout_irq |=> !timeout_irq)
		else $error("irq too long");
	chk_rst_pulse: assert property (sys_reset_req |=> !sys_reset_req)
		else $error("reset request too long");
	chk_one_response: assert property (!(timeout_irq && sys_reset_req))
		else $error("both responses");
	chk_recover_stop: assert property (stop_recover |-> $past(stop_mode))
		else $error("recovery outside stop");
	chk_no_reset_stop: assert property (sys_reset_req |-> !$past(stop_mode))
		else $error("reset in stop");
	chk_wdt_flag: assert property (status_read |=> reg_rdata[WDT_FLAG_BIT] == $past(wnow))
		else $error("watchdog flag wrong");
	chk_stop_flag: assert property (status_read |=> reg_rdata[STOP_FLAG_BIT] == $past(snow))
		else $error("stop flag wrong");
	chk_debug_quiet: assert property (debug_mode [*3] |-> !pulse)
		else $error("time-out in debug");
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// bench: device and controller joined by the link
// assumes the core package, link and both ends compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import wdt_pkg::*;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic always_on = 1'b0;
	logic resp_sel = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, running, st, rs, ev;
	logic [23:0] count, rl;
	logic [7:0] lfsr = 8'h1B;
	int fails = 0;
	int cmp_count = 0;
	int n;
	int mdl_lock = 0;
	logic [23:0] mdl_reload = RELOAD_RESET;
	wdt_if link();
	assign ev = link.timeout_irq | link.sys_reset_req | link.stop_recover;
	wdt_device #(.TICK_CYCLES(4)) wdt_device_i (.CLK(CLK), .RSTN(RSTN),
		.BUS(link), .ALWAYS_ON(always_on), .RESPONSE_SELECT(resp_sel),
		.RUNNING(running), .COUNT(count));
	wdt_controller wdt_controller_i (.CLK(CLK), .RSTN(RSTN), .BUS(link),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	wdt_asserts wdt_asserts_i (.CLK(CLK), .RSTN(RSTN),
		.reg_addr(link.reg_addr), .reg_rd(link.reg_rd),
		.reg_rdata(link.reg_rdata), .debug_mode(link.debug_mode),
		.stop_mode(link.stop_mode), .timeout_irq(link.timeout_irq),
		.sys_reset_req(link.sys_reset_req),
		.stop_recover(link.stop_recover));
	// ==========================================================
	// helpers
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(input logic [31:0] seen, exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge CLK);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rv = prdata;
		check(pslverr, 1'b0, "slave error");
		check(pready, 1'b1, "pready");
		if (pready !== 1'b1)
			test_done();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge CLK);
	endtask
	// rule model: unlock state and stored reload value
	task automatic model_write(input logic [11:0] a, input logic [7:0] d);
		int nxt;
		nxt = 0;
		if (mdl_lock == 0 && a == UNLOCK_CTRL_ADDR && d == UNLOCK_KEY_FIRST)
			nxt = 1;
		if (mdl_lock == 1 && a == UNLOCK_CTRL_ADDR && d == UNLOCK_KEY_SECOND)
			nxt = 2;
		if (mdl_lock == 2 && a == RELOAD_UPPER_ADDR) begin
			mdl_reload[23:16] = d;
			nxt = 3;
		end
		if (mdl_lock == 3 && a == RELOAD_HIGH_ADDR) begin
			mdl_reload[15:8] = d;
			nxt = 4;
		end
		if (mdl_lock == 4 && a == RELOAD_LOW_ADDR)
			mdl_reload[7:0] = d;
		mdl_lock = nxt;
	endtask
	task automatic lnk(input logic rd, input logic [11:0] a, input logic [7:0] d);
		int k;
		if (!rd)
			model_write(a, d);
		apb(1'b1, APB_ACCESS_ADDR, {7'h00, rd, 4'h0, a, d});
		k = 0;
		while (rd && k < 9) begin
			apb(1'b0, APB_ACCESS_ADDR, 32'h0);
			k = (rv[ACCESS_VALID_BIT] === 1'b1) ? 9 : k + 1;
		end
		if (rd)
			check(rv[ACCESS_VALID_BIT], 1'b1, "read valid");
		if (rd && rv[ACCESS_VALID_BIT] !== 1'b1)
			test_done();
	endtask
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	// ==========================================================
	// sequence
	initial begin
		repeat (12) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (20) @(posedge CLK);
		check(running, 1'b0, "idle");
		lfsr = nx(lfsr);
		// reload kept at least four
		rl = {16'h0001, 8'h80 | lfsr};
		lnk(1'b0, UNLOCK_CTRL_ADDR, UNLOCK_KEY_FIRST);
		lnk(1'b0, UNLOCK_CTRL_ADDR, UNLOCK_KEY_SECOND);
		lnk(1'b0, RELOAD_UPPER_ADDR, rl[23:16]);
		lnk(1'b0, RELOAD_HIGH_ADDR, rl[15:8]);
		lnk(1'b0, RELOAD_LOW_ADDR, rl[7:0]);
		lnk(1'b0, RELOAD_LOW_ADDR, 8'h11);
		lnk(1'b0, UNLOCK_CTRL_ADDR, UNLOCK_KEY_FIRST);
		lnk(1'b0, RELOAD_UPPER_ADDR, 8'h22);
		lnk(1'b0, UNLOCK_CTRL_ADDR, UNLOCK_KEY_SECOND);
		lnk(1'b0, RELOAD_UPPER_ADDR, 8'h33);
		apb(1'b1, APB_REFRESH_ADDR, 32'h0);
		@(posedge CLK);
		check(count, rl, "loaded");
		check(count, mdl_reload, "model reload");
		check(running, 1'b1, "running");
		lnk(1'b1, RELOAD_HIGH_ADDR, 8'h00);
		check(rv[7:0], rl[15:8], "live count");
		lnk(1'b1, UNLOCK_CTRL_ADDR, 8'h00);
		check(rv[5:4], 2'b00, "status");
		apb(1'b1, APB_MODE_ADDR, 32'h1);
		repeat (60) @(posedge CLK);
		check(count, rl, "debug reload");
		apb(1'b1, APB_MODE_ADDR, 32'h0);
		$display("test setup done");
		for (int i = 0; i < 4; i++) begin
			st = i[1];
			rs = i[0] ^ i[1];
			resp_sel <= rs;
			apb(1'b1, APB_MODE_ADDR, {30'h0, st, 1'b0});
			apb(1'b0, APB_MODE_ADDR, 32'h0);
			check(rv, {30'h0, st, 1'b0}, "mode");
			apb(1'b1, APB_EVENTS_ADDR, 32'h7);
			apb(1'b1, APB_REFRESH_ADDR, 32'h0);
			n = 0;
			while (count !== NO_REFRESH_COUNT && n < 4000) begin
				@(posedge CLK);
				n++;
			end
			check(count, NO_REFRESH_COUNT, "count two");
			if (count !== NO_REFRESH_COUNT)
				test_done();
			apb(1'b1, APB_REFRESH_ADDR, 32'h0);
			n = 0;
			while (ev !== 1'b1 && n < 40) begin
				@(posedge CLK);
				n++;
			end
			check(ev, 1'b1, "time-out");
			if (ev !== 1'b1)
				test_done();
			repeat (2) @(posedge CLK);
			apb(1'b0, APB_EVENTS_ADDR, 32'h0);
			check(rv, st ? (rs ? 4 : 5) : (rs ? 2 : 1), "events");
			lnk(1'b1, UNLOCK_CTRL_ADDR, 8'h00);
			check(rv[5:4], {1'b1, st}, "flags");
			check(count[23:16], 8'hFF, "wrapped");
			lnk(1'b1, UNLOCK_CTRL_ADDR, 8'h00);
			check(rv[5:4], 2'b00, "flags cleared");
			check(running, 1'b1, "still running");
			$display("test mode %0d done", i);
		end
		RSTN <= 1'b0;
		always_on <= 1'b1;
		mdl_lock = 0;
		mdl_reload = RELOAD_RESET;
		repeat (3) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (6) @(posedge CLK);
		check(running, 1'b1, "always on");
		check(count >= 24'h0003FE && count <= RELOAD_RESET, 1'b1, "ao load");
		$display("test always on done");
		test_done();
	end
endmodule
`default_nettype wire
